//--- ecm_controller.sv
// Behaviour
// [R01] Each word holds sixteen data bits and six generated check bits.
// [R02] Eight 128 KB banks; lower four base, upper four expansion.
// [R03] Every read compares stored check bits with recomputed ones.
// [R04] All single and double bit errors are detected.
// [R05] Syndrome identifies the single erroneous bit position.
// [R06] Single data-bit error is corrected by inversion.
// [R07] Single check-bit error leaves data unchanged, only reported.
// [R08] Double-bit errors are reported, never corrected.
// [R09] Any error latches syndrome and address and raises interrupt.
// [R10] Processor handler may scrub the location and log the error.
// [R11] Processor may access words or single bytes.
// [R12] Periodic refresh cycles arbitrated against processor accesses.
// [R13] Ready signalled after checking; processor cycle held until then.
// [R14] Byte write is read, correct, merge, regenerate check, write back.
`timescale 1ns/1ps
`default_nettype none
module ecm_controller #(
  parameter int REFRESH_INTERVAL = ecm_pkg::REFRESH_CYCLES,
  parameter bit EXPANSION = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Processor side
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic [1:0] cpuBytes,
  input wire logic [ecm_pkg::ADDR_W-1:0] cpuAddr,
  input wire logic [15:0] cpuWdata,
  output logic cpuReady,
  output logic [15:0] cpuRdata,
  output logic cpuFault,
  // Error report
  output logic errIrq,
  output logic [5:0] errSyndrome,
  output logic [ecm_pkg::ADDR_W-1:0] errAddr,
  output logic errDouble,
  input wire logic errAck,
  // Array side
  output logic ramRead,
  output logic ramWrite,
  output logic ramRefresh,
  output logic [ecm_pkg::BANK_W-1:0] ramBank,
  output logic [ecm_pkg::BANK_WORD_AW-1:0] ramAddr,
  output logic [21:0] ramWdata,
  input wire logic [21:0] ramRdata
);
  // Shorter intervals leave no room for an access between two refreshes
  if (REFRESH_INTERVAL < 8) begin : g_bad_interval
    $error("Refresh interval too short");
  end
  ecm_pkg::ecm_state_t state, next_state;
  logic [31:0] refCnt, next_refCnt;
  logic refPend, next_refPend;
  logic [2:0] busyCnt, next_busyCnt;
  logic [21:0] rdHold, next_rdHold;
  logic next_cpuReady, next_ramRead, next_ramWrite, next_ramRefresh;
  logic [15:0] next_cpuRdata;
  logic next_cpuFault, next_errIrq, next_errDouble;
  logic [5:0] next_errSyndrome;
  logic [ecm_pkg::ADDR_W-1:0] next_errAddr;
  logic [ecm_pkg::BANK_W-1:0] next_ramBank;
  logic [ecm_pkg::BANK_WORD_AW-1:0] next_ramAddr;
  logic [21:0] next_ramWdata;
  logic [5:0] genCheck, synd;
  logic [15:0] fixed, merged;
  logic sErr, dErr;
  logic bankOk;
  ecm_code decode (
    .data(rdHold[15:0]),
    .storedCheck(rdHold[21:16]),
    .check(),
    .syndrome(synd),
    .corrected(fixed),
    .singleErr(sErr),
    .doubleErr(dErr)
  );
  ecm_code encode (
    .data(merged),
    .storedCheck(6'h00),
    .check(genCheck),
    .syndrome(),
    .corrected(),
    .singleErr(),
    .doubleErr()
  );
  // Upper four banks exist only with the expansion board fitted [R02]
  assign bankOk = EXPANSION || (cpuAddr[ecm_pkg::ADDR_W-1] == 1'b0);
  always_comb begin
    merged = cpuWdata;
    if (!cpuBytes[0]) begin
      merged[7:0] = fixed[7:0]; // [R14] [R11]
    end
    if (!cpuBytes[1]) begin
      merged[15:8] = fixed[15:8]; // [R14] [R11]
    end
  end
  always_comb begin
    next_state = state;
    next_refCnt = refCnt + 32'h1;
    next_refPend = refPend;
    next_busyCnt = busyCnt;
    next_rdHold = rdHold;
    next_cpuReady = 1'b0;
    next_cpuRdata = cpuRdata;
    next_cpuFault = 1'b0;
    next_errIrq = errIrq && !errAck;
    next_errDouble = errDouble;
    next_errSyndrome = errSyndrome;
    next_errAddr = errAddr;
    next_ramRead = 1'b0;
    next_ramWrite = 1'b0;
    next_ramRefresh = 1'b0;
    next_ramBank = ramBank;
    next_ramAddr = ramAddr;
    next_ramWdata = ramWdata;
    unique case (state)
      ecm_pkg::ECM_IDLE: begin
        // Refresh wins over a waiting access; the processor simply stays held
        if (refPend) begin
          next_refPend = 1'b0;
          next_ramRefresh = 1'b1; // [R12]
          next_busyCnt = 3'(ecm_pkg::REFRESH_BUSY);
          next_state = ecm_pkg::ECM_REFRESH;
        end else if (cpuReq && !cpuReady && !cpuFault) begin
          next_ramBank = cpuAddr[ecm_pkg::ADDR_W-1 -: ecm_pkg::BANK_W];
          next_ramAddr = cpuAddr[ecm_pkg::BANK_WORD_AW-1:0];
          if (!bankOk) begin
            next_cpuFault = 1'b1;
            next_cpuReady = 1'b1;
          end else if (cpuWrite && cpuBytes == ecm_pkg::BYTE_BOTH) begin
            next_state = ecm_pkg::ECM_WRITE;
          end else begin
            next_ramRead = 1'b1; // [R03]
            next_state = ecm_pkg::ECM_READ;
          end
        end
      end
      ecm_pkg::ECM_READ: begin
        next_rdHold = ramRdata;
        next_state = ecm_pkg::ECM_CHECK;
      end
      ecm_pkg::ECM_CHECK: begin
        if (sErr || dErr) begin
          next_errIrq = 1'b1; // [R09]
          next_errSyndrome = synd; // [R09]
          next_errAddr = {ramBank, ramAddr}; // [R09]
          next_errDouble = dErr; // [R08]
        end
        if (cpuWrite) begin
          next_state = ecm_pkg::ECM_WRITE; // [R14]
        end else begin
          next_cpuRdata = fixed; // [R06] [R07]
          next_cpuReady = 1'b1; // [R13]
          next_state = ecm_pkg::ECM_IDLE;
        end
      end
      ecm_pkg::ECM_WRITE: begin
        next_ramWdata = {genCheck, merged}; // [R01] [R14]
        next_ramWrite = 1'b1;
        next_cpuReady = 1'b1;
        next_state = ecm_pkg::ECM_IDLE;
      end
      ecm_pkg::ECM_REFRESH: begin
        next_busyCnt = busyCnt - 3'h1;
        if (busyCnt == 3'h1) begin
          next_state = ecm_pkg::ECM_IDLE;
        end
      end
      default: begin
        next_state = ecm_pkg::ECM_IDLE;
      end
    endcase
    // After the case, so a new refresh request wins over the clear in idle
    if (refCnt >= 32'(REFRESH_INTERVAL - 1)) begin
      next_refCnt = 32'h0;
      next_refPend = 1'b1; // [R12]
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ecm_pkg::ECM_IDLE;
      refCnt <= 32'h0;
      refPend <= 1'b0;
      busyCnt <= 3'h0;
      rdHold <= 22'h000000;
      cpuReady <= 1'b0;
      cpuRdata <= 16'h0000;
      cpuFault <= 1'b0;
      errIrq <= 1'b0;
      errDouble <= 1'b0;
      errSyndrome <= 6'h00;
      errAddr <= '0;
      ramRead <= 1'b0;
      ramWrite <= 1'b0;
      ramRefresh <= 1'b0;
      ramBank <= '0;
      ramAddr <= '0;
      ramWdata <= 22'h000000;
    end else begin
      state <= next_state;
      refCnt <= next_refCnt;
      refPend <= next_refPend;
      busyCnt <= next_busyCnt;
      rdHold <= next_rdHold;
      cpuReady <= next_cpuReady;
      cpuRdata <= next_cpuRdata;
      cpuFault <= next_cpuFault;
      errIrq <= next_errIrq;
      errDouble <= next_errDouble;
      errSyndrome <= next_errSyndrome;
      errAddr <= next_errAddr;
      ramRead <= next_ramRead;
      ramWrite <= next_ramWrite;
      ramRefresh <= next_ramRefresh;
      ramBank <= next_ramBank;
      ramAddr <= next_ramAddr;
      ramWdata <= next_ramWdata;
    end
  end
endmodule
`default_nettype wire

//--- ecm_pkg.sv
`default_nettype none
package ecm_pkg;
  localparam int DATA_W = 16;
  localparam int CHECK_W = 6;
  localparam int WORD_W = DATA_W + CHECK_W;
  localparam int BANKS = 8;
  localparam int BASE_BANKS = 4;
  localparam int BANK_KBYTES = 128;
  localparam int BANK_WORD_AW = 16;
  localparam int BANK_W = 3;
  localparam int ADDR_W = BANK_W + BANK_WORD_AW;
  localparam int SYND_W = CHECK_W;
  localparam int REFRESH_NS = 15600;
  localparam int CLOCK_NS = 10;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLOCK_NS;
  localparam int REFRESH_BUSY = 4;
  localparam logic [1:0] BYTE_LOW = 2'h1;
  localparam logic [1:0] BYTE_HIGH = 2'h2;
  localparam logic [1:0] BYTE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    ECM_IDLE = 3'b000,
    ECM_READ = 3'b001,
    ECM_CHECK = 3'b010,
    ECM_WRITE = 3'b011,
    ECM_REFRESH = 3'b100
  } ecm_state_t;
endpackage
`default_nettype wire

//--- ecm_code.sv
`timescale 1ns/1ps
`default_nettype none
module ecm_code (
  // Raw word
  input wire logic [15:0] data,
  input wire logic [5:0] storedCheck,
  // Generated check and decode
  output logic [5:0] check,
  output logic [5:0] syndrome,
  output logic [15:0] corrected,
  output logic singleErr,
  output logic doubleErr
);
  // Hamming positions 1..21, parity position 0 overall; check bit k sits at position 2**k
  function automatic logic [4:0] dataPos(input int i);
    int p;
    int n;
    p = 0;
    n = 0;
    for (int q = 3; q < 22; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (n == i) begin
          p = q;
        end
        n++;
      end
    end
    return 5'(p);
  endfunction
  logic [4:0] hamm;
  logic overall;
  logic [4:0] storedH;
  logic [4:0] syn;
  logic parityBad;
  always_comb begin
    hamm = 5'h00;
    overall = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (data[i]) begin
        hamm = hamm ^ dataPos(i);
      end
      overall = overall ^ data[i];
    end
    check = {^{hamm, overall}, hamm}; // [R01]
    storedH = storedCheck[4:0];
    syn = hamm ^ storedH; // [R03]
    parityBad = ^{data, storedCheck};
    syndrome = {parityBad, syn};
    singleErr = parityBad; // [R04] [R05]
    doubleErr = !parityBad && (syn != 5'h00); // [R08]
    corrected = data;
    for (int i = 0; i < 16; i++) begin
      if (parityBad && syn == dataPos(i)) begin
        corrected[i] = ~data[i]; // [R06]
      end
    end
    // Check-bit positions match no data position, so data passes unchanged [R07]
  end
endmodule
`default_nettype wire

//--- ecm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ecm_asserts (
  // Watched ports
  input wire logic clock,
  input wire logic srst,
  input wire logic cpuWrite,
  input wire logic cpuReady,
  input wire logic cpuFault,
  input wire logic errIrq,
  input wire logic [5:0] errSyndrome,
  input wire logic errDouble,
  input wire logic errAck,
  input wire logic ramRead,
  input wire logic ramWrite,
  input wire logic ramRefresh,
  input wire logic [21:0] ramWdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence quiet4;
    (!ramRead && !ramWrite)[*4];
  endsequence
  sequence doneIn2;
    ##2 cpuReady;
  endsequence
  sequence doneIn3;
    ##3 (cpuReady && ramWrite);
  endsequence
  chk_ready_pulse: assert property (cpuReady |=> !cpuReady)
    else $error("ready too long");
  chk_read_done: assert property (ramRead && !cpuWrite |-> doneIn2)
    else $error("read answer late");
  chk_merge_done: assert property (ramRead && cpuWrite |-> doneIn3)
    else $error("merge write late");
  chk_write_ready: assert property (ramWrite |-> cpuReady)
    else $error("write without ready");
  chk_refresh_gap: assert property (ramRefresh |=> quiet4)
    else $error("access in refresh");
  chk_no_overlap: assert property (ramRead |-> !ramWrite && !ramRefresh)
    else $error("array strobes overlap");
  chk_check_parity: assert property (ramWrite |-> !(^ramWdata))
    else $error("bad overall parity");
  chk_irq_hold: assert property (errIrq && !errAck |=> errIrq)
    else $error("irq dropped");
  chk_double_synd: assert property (errDouble |-> !errSyndrome[5] && errSyndrome[4:0] != 5'h00)
    else $error("double flag wrong");
  chk_fault_ready: assert property (cpuFault |-> cpuReady)
    else $error("fault without ready");
endmodule
bind ecm_controller ecm_asserts i_chk (.clock(clock), .srst(srst), .cpuWrite(cpuWrite),
  .cpuReady(cpuReady),
  .cpuFault(cpuFault), .errIrq(errIrq), .errSyndrome(errSyndrome), .errDouble(errDouble),
  .errAck(errAck), .ramRead(ramRead), .ramWrite(ramWrite), .ramRefresh(ramRefresh),
  .ramWdata(ramWdata));
`default_nettype wire

//--- ecm_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecm_ram_model (
  // Array side
  input wire logic clock,
  input wire logic ramRead,
  input wire logic ramWrite,
  input wire logic [2:0] ramBank,
  input wire logic [15:0] ramAddr,
  input wire logic [21:0] ramWdata,
  // Fault injection
  input wire logic [21:0] flipMask,
  output logic [21:0] ramRdata
);
  // Small array: only the bank and the low four word-address bits select, so tests use distinct slots
  logic [21:0] mem [0:127];
  logic [21:0] lastRd = 22'h0;
  logic [6:0] idx;
  assign idx = {ramBank, ramAddr[3:0]};
  // The controller samples at the edge that ends its read strobe, so data stands during it
  // Outside a read the bus shows the inverse of the last word, so a stale sample never looks valid
  assign ramRdata = ramRead ? (mem[idx] ^ flipMask) : ~lastRd;
  always @(posedge clock) begin
    if (ramWrite) mem[idx] <= ramWdata;
    if (ramRead) lastRd <= mem[idx] ^ flipMask;
  end
endmodule
`default_nettype wire

//--- ecm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, srst, cpuReq, cpuWrite, errAck, cpuReady, cpuFault, errIrq, errDouble;
  logic ramRead, ramWrite, ramRefresh;
  logic cpuReqB, readyB, faultB;
  logic [1:0] cpuBytes;
  logic [18:0] cpuAddr, errAddr;
  logic [15:0] cpuWdata, cpuRdata, rd, ramAddr;
  logic [5:0] errSyndrome;
  logic [2:0] ramBank;
  logic [21:0] ramWdata, ramRdata, flipMask;
  int fail_count = 0;
  int checks_done = 0;
  int refreshes = 0;
  ecm_controller #(.REFRESH_INTERVAL(16)) i_dut (.clock(clock), .srst(srst),
    .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuBytes(cpuBytes), .cpuAddr(cpuAddr),
    .cpuWdata(cpuWdata), .cpuReady(cpuReady), .cpuRdata(cpuRdata), .cpuFault(cpuFault),
    .errIrq(errIrq), .errSyndrome(errSyndrome), .errAddr(errAddr), .errDouble(errDouble),
    .errAck(errAck), .ramRead(ramRead), .ramWrite(ramWrite), .ramRefresh(ramRefresh),
    .ramBank(ramBank), .ramAddr(ramAddr), .ramWdata(ramWdata), .ramRdata(ramRdata));
  ecm_ram_model i_ram (.clock(clock), .ramRead(ramRead), .ramWrite(ramWrite),
    .ramBank(ramBank), .ramAddr(ramAddr), .ramWdata(ramWdata), .flipMask(flipMask),
    .ramRdata(ramRdata));
  // Base-memory build: the upper four banks must answer with a fault
  ecm_controller #(.REFRESH_INTERVAL(16), .EXPANSION(1'b0)) i_dut_base (.clock(clock),
    .srst(srst), .cpuReq(cpuReqB), .cpuWrite(cpuWrite), .cpuBytes(cpuBytes), .cpuAddr(cpuAddr),
    .cpuWdata(cpuWdata), .cpuReady(readyB), .cpuRdata(), .cpuFault(faultB), .errIrq(),
    .errSyndrome(), .errAddr(), .errDouble(), .errAck(errAck), .ramRead(), .ramWrite(),
    .ramRefresh(), .ramBank(), .ramAddr(), .ramWdata(), .ramRdata(22'h000000));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (ramRefresh === 1'b1) refreshes++;
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // Request held until ready is sampled, then released
  task automatic access(input logic w, input logic [1:0] b, input logic [18:0] a,
    input logic [15:0] d);
    int n;
    step();
    step();
    cpuReq = 1'b1;
    cpuWrite = w;
    cpuBytes = b;
    cpuAddr = a;
    cpuWdata = d;
    n = 0;
    do @(posedge clock); while (cpuReady !== 1'b1 && ++n < 60);
    check(cpuReady === 1'b1 && cpuFault === 1'b0, "no ready");
    rd = cpuRdata;
    #1;
    cpuReq = 1'b0;
  endtask
  task automatic ack();
    errAck = 1'b1;
    step();
    errAck = 1'b0;
    step();
    check(errIrq === 1'b0, "irq not cleared");
  endtask
  task automatic t_word();
    access(1'b1, 2'h3, 19'h00000, 16'h1234);
    access(1'b1, 2'h3, 19'h7ffff, 16'hbeef);
    access(1'b0, 2'h3, 19'h00000, 16'h0000);
    check(rd === 16'h1234, "word bank 0");
    access(1'b0, 2'h3, 19'h7ffff, 16'h0000);
    check(rd === 16'hbeef && errIrq === 1'b0, "word bank 7");
    $display("t_word done");
  endtask
  // Error in the kept byte must be corrected before the merge
  task automatic t_byte();
    access(1'b1, 2'h3, 19'h00011, 16'haa55);
    flipMask = 22'h001000;
    access(1'b1, 2'h1, 19'h00011, 16'h003c);
    flipMask = 22'h0;
    check(errIrq === 1'b1, "merge error unseen");
    ack();
    access(1'b1, 2'h2, 19'h00011, 16'h7700);
    access(1'b0, 2'h1, 19'h00011, 16'h0000);
    check(rd === 16'h773c && errIrq === 1'b0, "byte merge");
    $display("t_byte done");
  endtask
  task automatic t_err();
    logic [21:0] m [6] = '{22'h1, 22'h8000, 22'h10000, 22'h200000, 22'h3, 22'h30000};
    logic [5:0] s [6] = '{6'h23, 6'h35, 6'h21, 6'h20, 6'h06, 6'h03};
    for (int i = 0; i < 6; i++) begin
      access(1'b1, 2'h3, 19'h20005, 16'hc3a5);
      flipMask = m[i];
      access(1'b0, 2'h3, 19'h20005, 16'h0000);
      flipMask = 22'h0;
      check(errIrq === 1'b1 && errAddr === 19'h20005, "capture");
      check(errDouble === (i > 3), "double flag");
      check(errSyndrome[5] === (i < 4) && errSyndrome === s[i], "syndrome");
      if (i < 4) check(rd === 16'hc3a5, "correction");
      ack();
    end
    check(refreshes > 0, "no refresh");
    $display("t_err done");
  endtask
  // Lower bank answers normally, upper bank with a fault, on the base-memory build
  task automatic t_fault();
    int n;
    for (int k = 0; k < 2; k++) begin
      step();
      step();
      cpuReqB = 1'b1;
      cpuWrite = 1'b0;
      cpuBytes = 2'h3;
      cpuAddr = (k == 1) ? 19'h50000 : 19'h10000;
      n = 0;
      do @(posedge clock); while (readyB !== 1'b1 && ++n < 60);
      check(readyB === 1'b1 && faultB === (k == 1), "expansion fault");
      #1;
      cpuReqB = 1'b0;
    end
    $display("t_fault done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    cpuReq = 1'b0;
    cpuReqB = 1'b0;
    cpuWrite = 1'b0;
    cpuBytes = 2'h0;
    cpuAddr = 19'h0;
    cpuWdata = 16'h0;
    errAck = 1'b0;
    flipMask = 22'h0;
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    t_word();
    t_byte();
    t_err();
    t_fault();
    give_verdict();
  end
endmodule
`default_nettype wire
